//--- converter_model.sv
// behavioural converter seen through the feedback pin and the headroom comparators
// assumes headroom grows with the feedback code; need_code is the balance point
`timescale 1ns/1ps
module converter_model (
	// clock
	input wire logic core_clk,
	// feedback pin
	input wire logic [8:0] fb_code,
	input wire logic fb_zero,
	// plant setup from the bench
	input wire logic [8:0] need_code,
	input wire logic slow,
	// comparator levels
	output logic [2:0] headroom_above
);
	logic [1:0] lag_ff = 2'h0;
	logic [2:0] above_ff = 3'h0;
	logic [2:0] nxt_above;
	assign headroom_above = above_ff;
	// comparator sense
	// dropped feedback current collapses the supply, so no headroom then
	always_comb begin
		nxt_above = (!fb_zero && fb_code > need_code) ? 3'h7 : 3'h0;
	end
	// slow plant moves every fourth cycle only, like a sluggish converter
	always @(posedge core_clk) begin
		lag_ff <= lag_ff + 2'h1;
		if (!slow || lag_ff == 2'h0) begin
			above_ff <= nxt_above;
		end
	end
endmodule

//--- headroom_regulation_loop.sv
// headroom regulation loop for three driver channels, with output gating,
// current dac update pacing and the register file of the block.
// assumes on pins and comparator levels are asynchronous; the timer gate,
// register port, readback strobe and channel inputs are on core_clk.
`timescale 1ns/1ps
module headroom_regulation_loop (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	// software controls without a register
	input wire logic polarity_invert,
	input wire logic readback_strobe,
	// channel pins and analog status
	input wire logic [2:0] channel_on_in,
	input wire logic [2:0] headroom_above,
	input wire logic [2:0] timer_gate,
	input regulation_pkg::chan_in_s [2:0] chan_in,
	// converter feedback
	output logic [8:0] fb_code,
	output logic fb_zero,
	output logic fb_range_double,
	output logic ref_power_en,
	output logic [4:0] headroom_target,
	// drivers
	output regulation_pkg::chan_out_s [2:0] chan_out,
	output logic drive_connect
);

	function automatic logic [8:0] step_code(input logic [8:0] code, input logic up);
		if (up)
			step_code = (code == regulation_pkg::CODE_MAX) ? code : code + 9'h001;
		else
			step_code = (code == 9'h000) ? code : code - 9'h001;
	endfunction

	// register file
	logic [7:0] ref_ctrl_ff, nxt_ref_ctrl, mode_one_ff, nxt_mode_one, setup_ff, nxt_setup;
	logic [7:0] out_cfg_ff [3], nxt_out_cfg [3];
	logic [5:0] scale_ff [3], nxt_scale [3];
	logic [7:0] hr_cfg_ff [3], nxt_hr_cfg [3];
	logic [7:0] timing_ff [3], nxt_timing [3];
	logic [8:0] rb_ff [3], nxt_rb [3];
	logic [7:0] rdata_ff, nxt_rdata;

	// synchronisers
	logic [2:0] on_s1_ff, on_s2_ff, on_d_ff, cmp_s1_ff, cmp_s2_ff;
	logic [2:0] on_rise;

	// loop state
	regulation_pkg::loop_state_e state_ff, nxt_state;
	logic [1:0] active_ff, nxt_active;
	logic [8:0] code_ff [3], nxt_code [3];
	logic [12:0] settle_ff, nxt_settle;
	logic [11:0] dec_ff, nxt_dec;
	logic [12:0] votes_ff, nxt_votes;
	logic [2:0] rate_ff, nxt_rate;

	// current dac pacing
	logic [4:0] tick_ff, nxt_tick;
	logic [12:0] pl_delay_ff [3], nxt_pl_delay [3];

	// outputs
	regulation_pkg::chan_out_s [2:0] chan_out_ff, nxt_chan_out;
	logic [8:0] fb_code_ff, nxt_fb_code;
	logic fb_zero_ff, nxt_fb_zero, connect_ff, nxt_connect, range_ff, nxt_range;
	logic [4:0] target_ff, nxt_target;

	logic blank;
	logic idac_tick;
	logic [1:0] rise_ch;
	logic [12:0] window;
	logic [12:0] votes_sum;
	logic dir_up;

	assign on_rise = on_s2_ff & ~on_d_ff;
	assign idac_tick = (tick_ff == 5'(regulation_pkg::IDAC_UPDATE_CYC - 1));
	assign blank = mode_one_ff[regulation_pkg::BLANK_MIN_BIT] & ~(|on_s2_ff);

	// register writes, reads and readback capture
	always_comb begin
		nxt_ref_ctrl = ref_ctrl_ff;
		nxt_mode_one = mode_one_ff;
		nxt_setup = setup_ff;
		nxt_rdata = 8'h00;
		if (reg_wr && reg_addr == regulation_pkg::REF_POWER_OFS) nxt_ref_ctrl = reg_wdata;
		if (reg_wr && reg_addr == regulation_pkg::MODE_ONE_OFS) nxt_mode_one = reg_wdata;
		if (reg_wr && reg_addr == regulation_pkg::LOOP_SETUP_OFS) nxt_setup = reg_wdata;
		if (reg_addr == regulation_pkg::REF_POWER_OFS) nxt_rdata = ref_ctrl_ff;
		if (reg_addr == regulation_pkg::MODE_ONE_OFS) nxt_rdata = mode_one_ff;
		if (reg_addr == regulation_pkg::LOOP_SETUP_OFS) nxt_rdata = setup_ff;
		for (int i = 0; i < 3; i++) begin
			nxt_out_cfg[i] = out_cfg_ff[i];
			nxt_scale[i] = scale_ff[i];
			nxt_hr_cfg[i] = hr_cfg_ff[i];
			nxt_timing[i] = timing_ff[i];
			nxt_rb[i] = rb_ff[i];
			if (reg_wr && reg_addr == regulation_pkg::OUT_CFG_OFS[i]) nxt_out_cfg[i] = reg_wdata;
			if (reg_wr && reg_addr == regulation_pkg::SCALE_OFS[i]) nxt_scale[i] = reg_wdata[5:0];
			if (reg_wr && reg_addr == regulation_pkg::HR_CFG_OFS[i]) nxt_hr_cfg[i] = reg_wdata;
			if (reg_wr && reg_addr == regulation_pkg::TIMING_OFS[i]) nxt_timing[i] = reg_wdata;
			if (readback_strobe) nxt_rb[i] = code_ff[i];
			if (reg_addr == regulation_pkg::OUT_CFG_OFS[i]) nxt_rdata = out_cfg_ff[i];
			if (reg_addr == regulation_pkg::SCALE_OFS[i]) nxt_rdata = {2'b00, scale_ff[i]};
			if (reg_addr == regulation_pkg::HR_CFG_OFS[i]) nxt_rdata = hr_cfg_ff[i];
			if (reg_addr == regulation_pkg::TIMING_OFS[i]) nxt_rdata = timing_ff[i];
			if (reg_addr == regulation_pkg::RB_LSB_OFS[i]) nxt_rdata = rb_ff[i][7:0];
			if (reg_addr == regulation_pkg::RB_MSB_OFS[i]) nxt_rdata = {7'h00, rb_ff[i][8]};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ref_ctrl_ff <= regulation_pkg::REG_RESET;
			mode_one_ff <= regulation_pkg::REG_RESET;
			setup_ff <= regulation_pkg::REG_RESET;
			rdata_ff <= 8'h00;
			for (int i = 0; i < 3; i++) begin
				out_cfg_ff[i] <= regulation_pkg::REG_RESET;
				scale_ff[i] <= regulation_pkg::SCALE_MAX;
				hr_cfg_ff[i] <= regulation_pkg::REG_RESET;
				timing_ff[i] <= regulation_pkg::REG_RESET;
				rb_ff[i] <= 9'h000;
			end
		end else begin
			ref_ctrl_ff <= nxt_ref_ctrl;
			mode_one_ff <= nxt_mode_one;
			setup_ff <= nxt_setup;
			rdata_ff <= nxt_rdata;
			for (int i = 0; i < 3; i++) begin
				out_cfg_ff[i] <= nxt_out_cfg[i];
				scale_ff[i] <= nxt_scale[i];
				hr_cfg_ff[i] <= nxt_hr_cfg[i];
				timing_ff[i] <= nxt_timing[i];
				rb_ff[i] <= nxt_rb[i];
			end
		end
	end

	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			on_s1_ff <= 3'h0;
			on_s2_ff <= 3'h0;
			on_d_ff <= 3'h0;
			cmp_s1_ff <= 3'h0;
			cmp_s2_ff <= 3'h0;
		end else begin
			on_s1_ff <= channel_on_in;
			on_s2_ff <= on_s1_ff;
			on_d_ff <= on_s2_ff;
			cmp_s1_ff <= headroom_above;
			cmp_s2_ff <= cmp_s1_ff;
		end
	end

	always_comb begin
		rise_ch = 2'd0;
		for (int i = 0; i < 3; i++)
			if (on_rise[i]) rise_ch = 2'(i);
	end

	// decimation 2^(field+4): field 7 gives 2048
	// shift amount needs four bits, three would wrap field 7 to a tiny window
	assign window = 13'h0001 << ({1'b0, hr_cfg_ff[active_ff][regulation_pkg::DEC_LSB +: 3]}
		+ 4'(regulation_pkg::DEC_BASE_LOG2));
	assign votes_sum = votes_ff + {12'h000, cmp_s2_ff[active_ff]};
	// with polarity_invert low, headroom above target lowers the code
	assign dir_up = ~((votes_sum << 1) > window) ^ polarity_invert;

	always_comb begin
		nxt_state = state_ff;
		nxt_active = active_ff;
		nxt_settle = settle_ff;
		nxt_dec = dec_ff;
		nxt_votes = votes_ff;
		nxt_rate = rate_ff;
		for (int i = 0; i < 3; i++) nxt_code[i] = code_ff[i];
		if ((|on_rise) && ref_ctrl_ff[regulation_pkg::REF_POWER_BIT]) begin
			nxt_active = rise_ch;
			nxt_dec = 12'h000;
			nxt_votes = 13'h0000;
			nxt_rate = 3'h0;
			nxt_state = regulation_pkg::LOOP_SETTLE;
			case (timing_ff[rise_ch][regulation_pkg::INIT_SEL_LSB +: 2])
				regulation_pkg::INIT_ZERO: nxt_code[rise_ch] = 9'h000;
				regulation_pkg::INIT_PRESET: nxt_code[rise_ch] = chan_in[rise_ch].preset_code;
				default: nxt_code[rise_ch] = code_ff[rise_ch];
			endcase
			nxt_settle = 13'(timing_ff[rise_ch][regulation_pkg::SETTLE_LSB +: 2])
				* 13'(regulation_pkg::SETTLE_STEP_CYC);
		end else begin
			case (state_ff)
				regulation_pkg::LOOP_IDLE: begin
					nxt_state = regulation_pkg::LOOP_IDLE;
				end
				regulation_pkg::LOOP_SETTLE: begin
					if (!on_s2_ff[active_ff] || !ref_ctrl_ff[regulation_pkg::REF_POWER_BIT])
						nxt_state = regulation_pkg::LOOP_IDLE;
					else if (settle_ff == 13'h0000)
						nxt_state = regulation_pkg::LOOP_TRACK;
					else
						nxt_settle = settle_ff - 13'h0001;
				end
				regulation_pkg::LOOP_TRACK: begin
					if (!on_s2_ff[active_ff] || !ref_ctrl_ff[regulation_pkg::REF_POWER_BIT]) begin
						nxt_state = regulation_pkg::LOOP_IDLE;
					end else if ({1'b0, dec_ff} == window - 13'h0001) begin
						nxt_dec = 12'h000;
						nxt_votes = 13'h0000;
						if (rate_ff == timing_ff[active_ff][regulation_pkg::RATE_LSB +: 3]) begin
							nxt_rate = 3'h0;
							nxt_code[active_ff] = step_code(code_ff[active_ff], dir_up);
						end else begin
							nxt_rate = rate_ff + 3'h1;
						end
					end else begin
						nxt_dec = dec_ff + 12'h001;
						nxt_votes = votes_sum;
					end
				end
				default: nxt_state = regulation_pkg::LOOP_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_ff <= regulation_pkg::LOOP_IDLE;
			active_ff <= 2'd0;
			settle_ff <= 13'h0000;
			dec_ff <= 12'h000;
			votes_ff <= 13'h0000;
			rate_ff <= 3'h0;
			for (int i = 0; i < 3; i++) code_ff[i] <= 9'h000;
		end else begin
			state_ff <= nxt_state;
			active_ff <= nxt_active;
			settle_ff <= nxt_settle;
			dec_ff <= nxt_dec;
			votes_ff <= nxt_votes;
			rate_ff <= nxt_rate;
			for (int i = 0; i < 3; i++) code_ff[i] <= nxt_code[i];
		end
	end

	// outputs; all channels share one converter so only the owner's code shows
	always_comb begin
		nxt_tick = idac_tick ? 5'h00 : tick_ff + 5'h01;
		nxt_fb_zero = blank;
		nxt_connect = ~blank;
		nxt_fb_code = blank ? 9'h000 : code_ff[active_ff];
		nxt_range = setup_ff[regulation_pkg::RANGE_DOUBLE_BIT];
		nxt_target = hr_cfg_ff[active_ff][regulation_pkg::HR_TARGET_LSB +: 5];
		for (int i = 0; i < 3; i++) begin
			nxt_pl_delay[i] = pl_delay_ff[i];
			nxt_chan_out[i] = chan_out_ff[i];
			if (on_rise[i])
				nxt_pl_delay[i] = 13'(chan_in[i].power_loop_delay)
					* 13'(regulation_pkg::SETTLE_STEP_CYC);
			else if (pl_delay_ff[i] != 13'h0000)
				nxt_pl_delay[i] = pl_delay_ff[i] - 13'h0001;
			if (idac_tick && !(chan_in[i].closed_loop_photocurrent_mode
				&& pl_delay_ff[i] != 13'h0000))
				nxt_chan_out[i].iout_dac = chan_in[i].iout_code;
			nxt_chan_out[i].scale = scale_ff[i];
			nxt_chan_out[i].drive_en = on_s2_ff[i] & timer_gate[i] & ~blank;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tick_ff <= 5'h00;
			fb_zero_ff <= 1'b0;
			connect_ff <= 1'b0;
			fb_code_ff <= 9'h000;
			range_ff <= 1'b0;
			target_ff <= 5'h00;
			for (int i = 0; i < 3; i++) begin
				pl_delay_ff[i] <= 13'h0000;
				// scale output at maximum from reset on
				chan_out_ff[i] <= '{iout_dac: 10'h000, scale: regulation_pkg::SCALE_MAX,
					drive_en: 1'b0};
			end
		end else begin
			tick_ff <= nxt_tick;
			fb_zero_ff <= nxt_fb_zero;
			connect_ff <= nxt_connect;
			fb_code_ff <= nxt_fb_code;
			range_ff <= nxt_range;
			target_ff <= nxt_target;
			for (int i = 0; i < 3; i++) begin
				pl_delay_ff[i] <= nxt_pl_delay[i];
				chan_out_ff[i] <= nxt_chan_out[i];
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign fb_code = fb_code_ff;
	assign fb_zero = fb_zero_ff;
	assign fb_range_double = range_ff;
	assign ref_power_en = ref_ctrl_ff[regulation_pkg::REF_POWER_BIT];
	assign headroom_target = target_ff;
	assign chan_out = chan_out_ff;
	assign drive_connect = connect_ff;

	// checks
	property p_saturate;
		@(posedge core_clk) disable iff (!rstn)
		(state_ff == regulation_pkg::LOOP_TRACK && code_ff[active_ff] == regulation_pkg::CODE_MAX
			&& on_rise == 3'h0)
		|=> code_ff[$past(active_ff)] >= 9'h1fe;
	endproperty
	a_saturate: assert property (p_saturate) else $error("code wrapped past top");
	property p_blank;
		@(posedge core_clk) disable iff (!rstn)
		blank |=> fb_zero && !drive_connect && fb_code == 9'h000;
	endproperty
	a_blank: assert property (p_blank) else $error("blanking not applied");
	property p_gate;
		@(posedge core_clk) disable iff (!rstn)
		(!on_s2_ff[0] || !timer_gate[0]) |=> !chan_out[0].drive_en;
	endproperty
	a_gate: assert property (p_gate) else $error("output driven while off");
	property p_readback;
		@(posedge core_clk) disable iff (!rstn)
		readback_strobe |=> rb_ff[1] == $past(code_ff[1]);
	endproperty
	a_readback: assert property (p_readback) else $error("readback not captured");
	property p_scale_reset;
		@(posedge core_clk)
		!rstn |=> scale_ff[2] == regulation_pkg::SCALE_MAX;
	endproperty
	a_scale_reset: assert property (p_scale_reset) else $error("scale not at max");
	property p_power;
		@(posedge core_clk) disable iff (!rstn)
		!ref_ctrl_ff[regulation_pkg::REF_POWER_BIT] [*2] |-> state_ff != regulation_pkg::LOOP_TRACK;
	endproperty
	a_power: assert property (p_power) else $error("loop runs unpowered");
	property p_settle;
		@(posedge core_clk) disable iff (!rstn)
		(state_ff == regulation_pkg::LOOP_SETTLE && settle_ff != 13'h0000)
		|=> state_ff != regulation_pkg::LOOP_TRACK;
	endproperty
	a_settle: assert property (p_settle) else $error("settle delay skipped");
	property p_pace;
		@(posedge core_clk) disable iff (!rstn)
		!idac_tick |=> $stable(chan_out[0].iout_dac);
	endproperty
	a_pace: assert property (p_pace) else $error("current dac updated off tick");
	property p_hold;
		@(posedge core_clk) disable iff (!rstn)
		(state_ff == regulation_pkg::LOOP_IDLE && on_rise == 3'h0) |=> $stable(code_ff[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("held code changed");

endmodule

//--- regulation_pkg.sv
// package for the headroom regulation loop: register map, field layout,
// reset values, timing counts and the per-channel carrier structs.
// assumes a 200 MHz core clock and an 8-bit register port behind the serial link.
package regulation_pkg;

	// register offsets
	localparam logic [7:0] REF_POWER_OFS = 8'h00;
	localparam logic [7:0] MODE_ONE_OFS = 8'h01;
	localparam logic [7:0] OUT_CFG_OFS [3] = '{8'h05, 8'h06, 8'h07};
	localparam logic [7:0] SCALE_OFS [3] = '{8'h12, 8'h16, 8'h1a};
	localparam logic [7:0] LOOP_SETUP_OFS = 8'h24;
	localparam logic [7:0] HR_CFG_OFS [3] = '{8'h2f, 8'h2b, 8'h27};
	localparam logic [7:0] TIMING_OFS [3] = '{8'h30, 8'h2c, 8'h28};
	localparam logic [7:0] RB_LSB_OFS [3] = '{8'h61, 8'h63, 8'h65};
	localparam logic [7:0] RB_MSB_OFS [3] = '{8'h62, 8'h64, 8'h66};

	// field positions
	localparam int REF_POWER_BIT = 4;
	localparam int INVERT_BIT = 3;
	localparam int BLANK_MIN_BIT = 7;
	localparam int RANGE_DOUBLE_BIT = 1;
	localparam int HR_TARGET_LSB = 3;
	localparam int DEC_LSB = 0;
	localparam int RATE_LSB = 5;
	localparam int INIT_SEL_LSB = 2;
	localparam int SETTLE_LSB = 0;

	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [5:0] SCALE_MAX = 6'h3f;

	// initial code selection
	localparam logic [1:0] INIT_HELD = 2'h0;
	localparam logic [1:0] INIT_ZERO = 2'h1;
	localparam logic [1:0] INIT_PRESET = 2'h2;

	// timing
	localparam int CLK_MHZ = 200;
	localparam int SETTLE_STEP_US = 10;
	localparam int SETTLE_STEP_CYC = SETTLE_STEP_US * CLK_MHZ;
	localparam int IDAC_KSPS = 12500;
	localparam int IDAC_UPDATE_CYC = (CLK_MHZ * 1000 + IDAC_KSPS - 1) / IDAC_KSPS;
	localparam int DEC_BASE_LOG2 = 4;
	localparam logic [8:0] CODE_MAX = 9'h1ff;

	typedef enum logic [1:0] {
		LOOP_IDLE = 2'b00,
		LOOP_SETTLE = 2'b01,
		LOOP_TRACK = 2'b11
	} loop_state_e;

	typedef struct packed {
		logic [8:0] preset_code;
		logic [1:0] power_loop_delay;
		logic closed_loop_photocurrent_mode;
		logic [9:0] iout_code;
	} chan_in_s;

	typedef struct packed {
		logic [9:0] iout_dac;
		logic [5:0] scale;
		logic drive_en;
	} chan_out_s;

endpackage

//--- testbench.sv
// self-checking bench for the headroom regulation loop
// assumes the package and the converter model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_rdata;
	logic polarity_invert = 1'b0;
	logic readback_strobe = 1'b0;
	logic [2:0] channel_on_in = 3'h0;
	logic [2:0] headroom_above;
	logic [2:0] timer_gate = 3'h0;
	regulation_pkg::chan_in_s [2:0] chan_in = '0;
	logic [8:0] fb_code;
	logic fb_zero;
	logic fb_range_double;
	logic ref_power_en;
	logic [4:0] headroom_target;
	regulation_pkg::chan_out_s [2:0] chan_out;
	logic drive_connect;
	logic [8:0] need_code = 9'h000;
	logic slow = 1'b0;
	logic [8:0] prev_code;
	logic step_watch = 1'b0;
	int mismatches = 0;
	int comparisons = 0;

	always #2.5 core_clk = ~core_clk;

	converter_model model (.core_clk, .fb_code, .fb_zero, .need_code, .slow, .headroom_above);
	headroom_regulation_loop dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rdata, .polarity_invert, .readback_strobe, .channel_on_in, .headroom_above,
		.timer_gate, .chan_in, .fb_code, .fb_zero, .fb_range_double, .ref_power_en,
		.headroom_target, .chan_out, .drive_connect);

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		cyc(1);
		reg_addr = a;
		cyc(1);
		d = reg_rdata;
	endtask

	function automatic logic [7:0] timing_val(logic [2:0] rate, logic [1:0] sel, logic [1:0] st);
		return {rate, 1'b0, sel, st};
	endfunction

	task automatic print_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// code may move by one at most while watched
	// sampled off the edge, once the registered code has settled
	always @(posedge core_clk) begin
		#1;
		prev_code <= fb_code;
		if (step_watch)
			`CHK("fb_step", 1'b1, fb_code == prev_code || fb_code == prev_code + 9'd1 || fb_code + 9'd1 == prev_code)
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		print_verdict;
	end

	initial begin
		logic [7:0] q;
		logic [7:0] v;
		logic [8:0] p;
		logic [9:0] old_i;
		void'($urandom(32'h2bd343e2));
		repeat (3) @(posedge core_clk);
		#1 rstn = 1'b1;
		cyc(2);
		`CHK("drive_connect", 1'b1, drive_connect)
		for (int i = 0; i < 3; i++) begin
			rd(regulation_pkg::SCALE_OFS[i], q);
			`CHK("scale_reg", 8'h3f, q)
			`CHK("scale_out", 6'h3f, chan_out[i].scale)
		end
		wr(regulation_pkg::RB_LSB_OFS[0], 8'h5a);
		rd(regulation_pkg::RB_LSB_OFS[0], q);
		`CHK("rb_readonly", 8'h00, q)
		rd(8'hf0, q);
		`CHK("unmapped", 8'h00, q)
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom);
			for (int i = 0; i < 3; i++)
				wr(regulation_pkg::HR_CFG_OFS[i], v + 8'(i));
			for (int i = 0; i < 3; i++) begin
				rd(regulation_pkg::HR_CFG_OFS[i], q);
				`CHK("hr_cfg", v + 8'(i), q)
			end
		end
		for (int i = 0; i < 3; i++) begin
			v = 8'($urandom);
			wr(regulation_pkg::SCALE_OFS[i], v);
			rd(regulation_pkg::SCALE_OFS[i], q);
			`CHK("scale_wr", ({2'b00, v[5:0]}), q)
			`CHK("scale_wr_out", v[5:0], chan_out[i].scale)
		end
		wr(regulation_pkg::REF_POWER_OFS, 8'h10);
		wr(regulation_pkg::LOOP_SETUP_OFS, 8'h02);
		cyc(1);
		`CHK("ref_power_en", 1'b1, ref_power_en)
		`CHK("range_double", 1'b1, fb_range_double)
		wr(regulation_pkg::LOOP_SETUP_OFS, 8'h00);
		wr(regulation_pkg::HR_CFG_OFS[0], {5'd9, 3'd0});
		wr(regulation_pkg::TIMING_OFS[0], timing_val(3'd0, regulation_pkg::INIT_ZERO, 2'd0));
		need_code = 9'd40;
		slow = 1'b1;
		channel_on_in = 3'b001;
		step_watch = 1'b1;
		cyc(1500);
		`CHK("target_ch0", 5'd9, headroom_target)
		`CHK("converged", 1'b1, fb_code >= 9'd37 && fb_code <= 9'd43)
		channel_on_in = 3'b000;
		cyc(10);
		p = fb_code;
		need_code = 9'd300;
		cyc(200);
		`CHK("held", p, fb_code)
		for (int j = 0; j < 2; j++) begin
			wr(regulation_pkg::TIMING_OFS[0], timing_val(3'd0, j ? 2'b11 : 2'b00, 2'd0));
			p = fb_code;
			channel_on_in = 3'b001;
			cyc(8);
			`CHK("resume", p, fb_code)
			channel_on_in = 3'b000;
			cyc(10);
		end
		step_watch = 1'b0;
		p = 9'd480 + 9'($urandom_range(20));
		chan_in[1].preset_code = p;
		wr(regulation_pkg::HR_CFG_OFS[1], {5'd3, 3'd0});
		wr(regulation_pkg::TIMING_OFS[1], timing_val(3'd0, regulation_pkg::INIT_PRESET, 2'd0));
		need_code = 9'd0;
		polarity_invert = 1'b1;
		channel_on_in = 3'b001;
		cyc(20);
		channel_on_in = 3'b011;
		cyc(8);
		`CHK("preset", p, fb_code)
		`CHK("owner_target", 5'd3, headroom_target)
		cyc(100);
		`CHK("inverted_up", 1'b1, fb_code > p)
		cyc(500);
		`CHK("sat_top", regulation_pkg::CODE_MAX, fb_code)
		wr(regulation_pkg::HR_CFG_OFS[2], 8'hff);
		wr(regulation_pkg::TIMING_OFS[2], timing_val(3'd0, regulation_pkg::INIT_ZERO, 2'd0));
		channel_on_in = 3'b111;
		cyc(8);
		`CHK("full_target", 5'h1f, headroom_target)
		// code not above need steps up, but only once per 2048-cycle window
		polarity_invert = 1'b0;
		cyc(1990);
		`CHK("dec_hold", 9'h000, fb_code)
		cyc(100);
		`CHK("dec_step", 9'h001, fb_code)
		channel_on_in = 3'b000;
		cyc(10);
		readback_strobe = 1'b1;
		cyc(1);
		readback_strobe = 1'b0;
		for (int i = 1; i < 3; i++) begin
			rd(regulation_pkg::RB_LSB_OFS[i], q);
			rd(regulation_pkg::RB_MSB_OFS[i], v);
			`CHK("readback", ((i == 1) ? regulation_pkg::CODE_MAX : 9'h001), ({v[0], q}))
		end
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 3; i++)
				chan_in[i].iout_code = 10'($urandom);
			timer_gate = 3'($urandom);
			channel_on_in = 3'($urandom);
			cyc(40);
			for (int i = 0; i < 3; i++) begin
				`CHK("drive_en", channel_on_in[i] & timer_gate[i], chan_out[i].drive_en)
				`CHK("iout_dac", chan_in[i].iout_code, chan_out[i].iout_dac)
			end
		end
		wr(regulation_pkg::MODE_ONE_OFS, 8'h80);
		channel_on_in = 3'b000;
		cyc(2100);
		`CHK("fb_zero", 1'b1, fb_zero)
		`CHK("fb_blank", 9'h000, fb_code)
		`CHK("disconnect", 1'b0, drive_connect)
		channel_on_in = 3'b010;
		cyc(10);
		`CHK("reconnect", 1'b1, drive_connect)
		wr(regulation_pkg::MODE_ONE_OFS, 8'h00);
		channel_on_in = 3'b000;
		cyc(30);
		old_i = chan_in[0].iout_code;
		chan_in[0].closed_loop_photocurrent_mode = 1'b1;
		chan_in[0].power_loop_delay = 2'd1;
		wr(regulation_pkg::TIMING_OFS[2], timing_val(3'd1, regulation_pkg::INIT_ZERO, 2'd1));
		wr(regulation_pkg::HR_CFG_OFS[2], 8'h00);
		polarity_invert = 1'b0;
		need_code = 9'd100;
		channel_on_in = 3'b101;
		cyc(10);
		chan_in[0].iout_code = ~old_i;
		cyc(1490);
		`CHK("idac_held", old_i, chan_out[0].iout_dac)
		`CHK("settle_hold", 9'h000, fb_code)
		cyc(700);
		`CHK("idac_new", ~old_i, chan_out[0].iout_dac)
		`CHK("settle_done", 1'b1, fb_code != 9'h000)
		// rate field 1: one step per two 16-cycle windows, about six by now
		`CHK("rate_pace", 1'b1, fb_code >= 9'd5 && fb_code <= 9'd7)
		print_verdict;
	end
endmodule
